/* pod_pkg.sv */
package pod_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 25_000_000;
	localparam int unsigned BLINK_HALF_MS = 125;
	localparam int unsigned BLINK_HALF_CYCLES = (CLK_HZ / 1000) * BLINK_HALF_MS;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W         = 4;
	localparam logic [3:0]  OFS_CTRL       = 4'h0;
	localparam logic [3:0]  OFS_STATUS     = 4'h4;
	localparam logic [3:0]  OFS_IRQ_STATUS = 4'h8;
	localparam logic [3:0]  OFS_IRQ_MASK   = 4'hc;

	// Control register fields
	localparam int unsigned CTRL_SEL_LO    = 0;
	localparam int unsigned CTRL_START     = 2;
	localparam int unsigned CTRL_DONE      = 3;
	localparam int unsigned CTRL_LINK      = 4;
	localparam int unsigned CTRL_FAULT_CLR = 5;

	// Status register fields
	localparam int unsigned ST_VREF_SER  = 0;
	localparam int unsigned ST_VREF_PAR  = 1;
	localparam int unsigned ST_POWER     = 2;
	localparam int unsigned ST_FAULT     = 3;
	localparam int unsigned ST_ID_LO     = 4;
	localparam int unsigned ST_SEL_LO    = 8;

	// Interrupt bits
	localparam int unsigned IRQ_W       = 4;
	localparam int unsigned IRQ_FAULT   = 0;
	localparam int unsigned IRQ_ADAPTER = 1;
	localparam int unsigned IRQ_VREF    = 2;
	localparam int unsigned IRQ_DONE    = 3;

	localparam int unsigned ID_W = 4;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SEL_SERIAL   = 2'h0,
		SEL_PARALLEL = 2'h1,
		SEL_ADAPTER  = 2'h2
	} port_sel_e;

	typedef enum logic [1:0] {
		PWR_IDLE  = 2'h0,
		PWR_ON    = 2'h1,
		PWR_FAULT = 2'h3
	} pwr_state_e;

	typedef struct packed {
		logic red;
		logic green;
	} lamp_s;

	typedef struct packed {
		logic             valid;
		logic             write;
		logic [3:0]       ofs;
	} ahb_addr_s;

	localparam lamp_s LAMP_OFF   = '{red: 1'b0, green: 1'b0};
	localparam lamp_s LAMP_RED   = '{red: 1'b1, green: 1'b0};
	localparam lamp_s LAMP_GREEN = '{red: 1'b0, green: 1'b1};
	localparam lamp_s LAMP_AMBER = '{red: 1'b1, green: 1'b1};

endpackage : pod_pkg

/* sync_bits.sv */
`timescale 1ns/100ps
module sync_bits #(
	parameter int unsigned W = 1
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] stage1;
	logic [W-1:0] next_stage1;
	logic [W-1:0] next_q;

	// Two-flop chain, first stage read only by the second
	always_comb begin
		next_stage1 = d;
		next_q      = stage1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1 <= '0;
			q      <= '0;
		end else begin
			stage1 <= next_stage1;
			q      <= next_q;
		end
	end

endmodule : sync_bits

/* blink_timer.sv */
`timescale 1ns/100ps
module blink_timer #(
	parameter int unsigned HALF_CYCLES = pod_pkg::BLINK_HALF_CYCLES
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	output logic      phase
);

	localparam int unsigned CNT_W = $clog2(HALF_CYCLES + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYCLES - 1);

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic             next_phase;

	// Free-running half-period counter toggling the blink phase
	always_comb begin
		next_cnt   = cnt + CNT_W'(1);
		next_phase = phase;
		if (cnt == LAST) begin
			next_cnt   = '0;
			next_phase = ~phase;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt   <= '0;
			phase <= 1'b0;
		end else begin
			cnt   <= next_cnt;
			phase <= next_phase;
		end
	end

endmodule : blink_timer

/* port_status_and_adapter_power.sv */
// What this block does
// R1 - Adapter power goes on when programming starts, off when it completes.
// R2 - Adapter red lamp lit exactly while adapter power is on.
// R3 - Adapter type code is sensed and shown to software.
// R4 - While powered, an over-current removes adapter power at once.
// R5 - A port lamp shows red when that port is not selected; amber while the link bit is clear.
// R6 - Selected port lamp shows amber when its reference voltage is absent.
// R7 - Selected port lamp shows green when its reference voltage is present; amber while the link bit is clear.
// R8 - With the adapter selected both port lamps show red; both amber while the link bit is clear.
// R9 - After reset the serial port is the selected port.
// R10 - After an adapter over-current both port lamps blink red; steady amber while the link bit is clear.
// R11 - All signals of non-selected ports are held released.
// R12 - Exactly one port is selected at all times; blink near four hertz.
// R13 - Over-current is latched; power stays off until new start or clear.
`timescale 1ns/100ps
module port_status_and_adapter_power #(
	parameter int unsigned BLINK_HALF_CYCLES = pod_pkg::BLINK_HALF_CYCLES,
	parameter int unsigned ID_W              = pod_pkg::ID_W
) (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	// Pod pins
	input  wire logic                 vref_serial_in,
	input  wire logic                 vref_parallel_in,
	input  wire logic                 overcurrent_in,
	input  wire logic [ID_W-1:0]      adapter_id_in,
	output logic                      adapter_power,
	output logic                      adapter_lamp,
	output pod_pkg::lamp_s            serial_lamp,
	output pod_pkg::lamp_s            parallel_config_port_lamp,
	output logic                      serial_port_oe_n,
	output logic                      parallel_config_port_oe_n,
	output logic                      adapter_port_oe_n,
	output logic                      irq
);

	// ----------------------------------------------------------------
	// Pin synchronisers and blink timer
	// ----------------------------------------------------------------
	// Every pin comes from off-board, so each one passes two flops
	// before any logic reads it; adapter code bits are synced alike
	localparam int unsigned PIN_W = ID_W + 3;

	logic [PIN_W-1:0] pins_sync;
	logic             vref_ser;
	logic             vref_par;
	logic             overcurrent;
	logic [ID_W-1:0]  adapter_id;
	logic             blink_phase;

	sync_bits #(
		.W       (PIN_W)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       ({adapter_id_in, overcurrent_in, vref_parallel_in, vref_serial_in}),
		.q       (pins_sync)
	);

	assign vref_ser    = pins_sync[0];
	assign vref_par    = pins_sync[1];
	assign overcurrent = pins_sync[2];
	assign adapter_id  = pins_sync[PIN_W-1:3];

	blink_timer #(
		.HALF_CYCLES (BLINK_HALF_CYCLES)
	) u_blink (
		.hclk    (hclk),
		.hresetn (hresetn),
		.phase   (blink_phase)            // R12
	);

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	pod_pkg::ahb_addr_s aph;
	pod_pkg::ahb_addr_s next_aph;
	logic [31:0]        next_hrdata;
	logic               wr_ctrl;
	logic               wr_irq_status;
	logic               wr_irq_mask;

	// Capture the address phase of every selected transfer
	always_comb begin
		next_aph.valid = hsel & hready & htrans[1];
		next_aph.write = hwrite;
		next_aph.ofs   = haddr[pod_pkg::ADDR_W-1:0];
	end

	// hreadyout never drops, so no transfer waits and none is stretched
	// Write strobes in the data phase
	assign wr_ctrl       = aph.valid & aph.write & (aph.ofs == pod_pkg::OFS_CTRL);
	assign wr_irq_status = aph.valid & aph.write & (aph.ofs == pod_pkg::OFS_IRQ_STATUS);
	assign wr_irq_mask   = aph.valid & aph.write & (aph.ofs == pod_pkg::OFS_IRQ_MASK);

	// ----------------------------------------------------------------
	// Port selection and control bits
	// ----------------------------------------------------------------
	pod_pkg::port_sel_e port_sel;
	pod_pkg::port_sel_e next_port_sel;
	logic               host_link;
	logic               next_host_link;
	logic               start_req;
	logic               done_req;
	logic               fault_clr;
	logic [1:0]         sel_wr;

	assign sel_wr    = hwdata[pod_pkg::CTRL_SEL_LO +: 2];
	assign start_req = wr_ctrl & hwdata[pod_pkg::CTRL_START];
	assign done_req  = wr_ctrl & hwdata[pod_pkg::CTRL_DONE];
	assign fault_clr = wr_ctrl & hwdata[pod_pkg::CTRL_FAULT_CLR];

	// Only legal codes change the selection, so one port is always chosen
	// Link is rewritten by every control write, selection only by a legal code
	always_comb begin
		next_port_sel  = port_sel;
		next_host_link = host_link;
		if (wr_ctrl) begin
			next_host_link = hwdata[pod_pkg::CTRL_LINK];
			case (sel_wr)
				2'h0:    next_port_sel = pod_pkg::SEL_SERIAL;
				2'h1:    next_port_sel = pod_pkg::SEL_PARALLEL;
				2'h2:    next_port_sel = pod_pkg::SEL_ADAPTER;
				default: next_port_sel = port_sel;        // R12
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Adapter power state machine
	// ----------------------------------------------------------------
	pod_pkg::pwr_state_e pwr_state;
	pod_pkg::pwr_state_e next_pwr_state;
	logic                adapter_sel;

	// Judged on the selection being written, so one write may choose the
	// adapter and start, and a write choosing another port cuts power at
	// the same edge that releases the adapter port
	assign adapter_sel = (next_port_sel == pod_pkg::SEL_ADAPTER);

	// Power on start, off on completion, latched off on over-current
	// A start while faulted retries at once; the fault latch is the guard
	always_comb begin
		next_pwr_state = pwr_state;
		case (pwr_state)
			pod_pkg::PWR_IDLE: begin
				if (start_req && adapter_sel)
					next_pwr_state = pod_pkg::PWR_ON;    // R1
			end
			pod_pkg::PWR_ON: begin
				if (overcurrent)
					next_pwr_state = pod_pkg::PWR_FAULT; // R4
				else if (done_req || !adapter_sel)
					next_pwr_state = pod_pkg::PWR_IDLE;  // R1
			end
			pod_pkg::PWR_FAULT: begin
				if (start_req && adapter_sel)
					next_pwr_state = pod_pkg::PWR_ON;    // R13
				else if (fault_clr)
					next_pwr_state = pod_pkg::PWR_IDLE;  // R13
			end
			default: next_pwr_state = pod_pkg::PWR_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Events and interrupt registers
	// ----------------------------------------------------------------
	logic [ID_W-1:0]          id_prev;
	logic [1:0]               vref_prev;
	logic [pod_pkg::IRQ_W-1:0] irq_status;
	logic [pod_pkg::IRQ_W-1:0] irq_mask;
	logic [pod_pkg::IRQ_W-1:0] next_irq_status;
	logic [pod_pkg::IRQ_W-1:0] next_irq_mask;
	logic [pod_pkg::IRQ_W-1:0] events;
	logic                      next_irq;

	// The code register starts at zero, so the first adapter code seen
	// after reset is reported as a change; software reads it then
	// Hardware events feeding the sticky status bits
	always_comb begin
		events = '0;
		events[pod_pkg::IRQ_FAULT]   = (pwr_state == pod_pkg::PWR_ON) &&
		                               (next_pwr_state == pod_pkg::PWR_FAULT);
		events[pod_pkg::IRQ_ADAPTER] = (adapter_id != id_prev);          // R3
		events[pod_pkg::IRQ_VREF]    = ({vref_par, vref_ser} != vref_prev);
		events[pod_pkg::IRQ_DONE]    = (pwr_state == pod_pkg::PWR_ON) &&
		                               (next_pwr_state == pod_pkg::PWR_IDLE);
	end

	// Write-one-to-clear, a coincident event wins over the clear
	always_comb begin
		next_irq_status = irq_status;
		next_irq_mask   = irq_mask;
		if (wr_irq_status)
			next_irq_status = irq_status & ~hwdata[pod_pkg::IRQ_W-1:0];
		next_irq_status = next_irq_status | events;
		if (wr_irq_mask)
			next_irq_mask = hwdata[pod_pkg::IRQ_W-1:0];
		next_irq = |(next_irq_status & next_irq_mask);
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [31:0] status_word;

	// Live status of the block
	always_comb begin
		status_word = '0;
		status_word[pod_pkg::ST_VREF_SER]           = vref_ser;
		status_word[pod_pkg::ST_VREF_PAR]           = vref_par;
		status_word[pod_pkg::ST_POWER]              = adapter_power;
		status_word[pod_pkg::ST_FAULT]              = (pwr_state == pod_pkg::PWR_FAULT);
		status_word[pod_pkg::ST_ID_LO +: ID_W]      = adapter_id;    // R3
		status_word[pod_pkg::ST_SEL_LO +: 2]        = port_sel;
	end

	// A read right behind a write to the same register sees the new word,
	// because this mux looks ahead in the address phase
	// Read mux sampled in the address phase, unmapped reads return zero
	always_comb begin
		next_hrdata = '0;
		if (next_aph.valid && !hwrite) begin
			case (haddr[pod_pkg::ADDR_W-1:0])
				pod_pkg::OFS_CTRL: begin
					next_hrdata[pod_pkg::CTRL_SEL_LO +: 2] = next_port_sel;
					next_hrdata[pod_pkg::CTRL_LINK]        = next_host_link;
				end
				pod_pkg::OFS_STATUS:     next_hrdata = status_word;
				pod_pkg::OFS_IRQ_STATUS: next_hrdata[pod_pkg::IRQ_W-1:0] = next_irq_status;
				pod_pkg::OFS_IRQ_MASK:   next_hrdata[pod_pkg::IRQ_W-1:0] = next_irq_mask;
				default:                 next_hrdata = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Lamps and port drivers
	// ----------------------------------------------------------------
	pod_pkg::lamp_s next_serial_lamp;
	pod_pkg::lamp_s next_parallel_lamp;
	logic           next_power;
	logic           next_ser_oe_n;
	logic           next_par_oe_n;
	logic           next_adp_oe_n;

	// The blink timer runs free, so the first dark half after a fault may
	// be short; that only shifts the phase, never the rate
	// Lamp colours from selection, reference voltage and fault
	always_comb begin
		next_power         = (next_pwr_state == pod_pkg::PWR_ON);    // R1 R4
		next_serial_lamp   = pod_pkg::LAMP_RED;                      // R5
		next_parallel_lamp = pod_pkg::LAMP_RED;                      // R5
		if (!next_host_link) begin
			next_serial_lamp   = pod_pkg::LAMP_AMBER;
			next_parallel_lamp = pod_pkg::LAMP_AMBER;
		end else begin
			case (next_port_sel)
				pod_pkg::SEL_SERIAL:
					next_serial_lamp = vref_ser ? pod_pkg::LAMP_GREEN : pod_pkg::LAMP_AMBER;   // R6 R7
				pod_pkg::SEL_PARALLEL:
					next_parallel_lamp = vref_par ? pod_pkg::LAMP_GREEN : pod_pkg::LAMP_AMBER; // R6 R7
				pod_pkg::SEL_ADAPTER: begin
					if (next_pwr_state == pod_pkg::PWR_FAULT && !blink_phase) begin
						next_serial_lamp   = pod_pkg::LAMP_OFF;       // R10
						next_parallel_lamp = pod_pkg::LAMP_OFF;       // R10
					end
				end                                                  // R8
				default: begin
					next_serial_lamp   = pod_pkg::LAMP_RED;
					next_parallel_lamp = pod_pkg::LAMP_RED;
				end
			endcase
		end
		// Only the selected port drives its target
		next_ser_oe_n = (next_port_sel != pod_pkg::SEL_SERIAL);     // R11
		next_par_oe_n = (next_port_sel != pod_pkg::SEL_PARALLEL);   // R11
		next_adp_oe_n = (next_port_sel != pod_pkg::SEL_ADAPTER);    // R11
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	// Lamps come out of reset amber, the no-host pattern, until software
	// sets the link bit
	// All registered state and outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph                       <= '0;
			hreadyout                 <= 1'b1;
			hresp                     <= 1'b0;
			hrdata                    <= '0;
			port_sel                  <= pod_pkg::SEL_SERIAL;   // R9
			host_link                 <= 1'b0;
			pwr_state                 <= pod_pkg::PWR_IDLE;
			id_prev                   <= '0;
			vref_prev                 <= '0;
			irq_status                <= '0;
			irq_mask                  <= '0;
			irq                       <= 1'b0;
			adapter_power             <= 1'b0;
			adapter_lamp              <= 1'b0;
			serial_lamp               <= pod_pkg::LAMP_AMBER;
			parallel_config_port_lamp <= pod_pkg::LAMP_AMBER;
			serial_port_oe_n          <= 1'b0;
			parallel_config_port_oe_n <= 1'b1;
			adapter_port_oe_n         <= 1'b1;
		end else begin
			aph                       <= next_aph;
			hreadyout                 <= 1'b1;
			hresp                     <= 1'b0;
			hrdata                    <= next_hrdata;
			port_sel                  <= next_port_sel;
			host_link                 <= next_host_link;
			pwr_state                 <= next_pwr_state;
			id_prev                   <= adapter_id;
			vref_prev                 <= {vref_par, vref_ser};
			irq_status                <= next_irq_status;
			irq_mask                  <= next_irq_mask;
			irq                       <= next_irq;
			adapter_power             <= next_power;
			adapter_lamp              <= next_power;             // R2
			serial_lamp               <= next_serial_lamp;
			parallel_config_port_lamp <= next_parallel_lamp;
			serial_port_oe_n          <= next_ser_oe_n;
			parallel_config_port_oe_n <= next_par_oe_n;
			adapter_port_oe_n         <= next_adp_oe_n;
		end
	end

endmodule : port_status_and_adapter_power

/* target_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Target side: reference rails, adapter load and adapter code
// ----------------------------------------------------------------
module target_model (
	input  wire logic       adapter_power,
	input  wire logic       shorted,
	input  wire logic       vref_ser_on,
	input  wire logic       vref_par_on,
	input  wire logic [3:0] id,
	output logic            vref_serial_in,
	output logic            vref_parallel_in,
	output logic            overcurrent_in,
	output logic [3:0]      adapter_id_in
);
	// A shorted part only draws current while the pod powers it
	assign overcurrent_in   = adapter_power & shorted;
	assign vref_serial_in   = vref_ser_on;
	assign vref_parallel_in = vref_par_on;
	assign adapter_id_in    = id;
endmodule : target_model

/* pod_chk.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module pod_chk (
	input wire logic           hclk,
	input wire logic           hresetn,
	input wire logic           vref_serial_in,
	input wire logic           overcurrent_in,
	input wire logic           adapter_power,
	input wire logic           adapter_lamp,
	input wire pod_pkg::lamp_s serial_lamp,
	input wire pod_pkg::lamp_s parallel_config_port_lamp,
	input wire logic           serial_port_oe_n,
	input wire logic           parallel_config_port_oe_n,
	input wire logic           adapter_port_oe_n
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_lamp_pwr; adapter_lamp == adapter_power; endproperty
	a_lamp_pwr: assert property (p_lamp_pwr) else $error("adapter lamp differs from power");
	property p_one_port;
		$countones({serial_port_oe_n, parallel_config_port_oe_n, adapter_port_oe_n}) == 2;
	endproperty
	a_one_port: assert property (p_one_port) else $error("not exactly one port driving");
	property p_ovc_cut; adapter_power && overcurrent_in |-> ##[1:4] !adapter_power; endproperty
	a_ovc_cut: assert property (p_ovc_cut) else $error("power kept on over-current");
	property p_pwr_sel; adapter_power |-> !adapter_port_oe_n; endproperty
	a_pwr_sel: assert property (p_pwr_sel) else $error("power on without adapter port");
	property p_unsel_ser; serial_port_oe_n |-> serial_lamp != pod_pkg::LAMP_GREEN; endproperty
	a_unsel_ser: assert property (p_unsel_ser) else $error("idle serial lamp green");
	property p_unsel_par;
		parallel_config_port_oe_n |-> parallel_config_port_lamp != pod_pkg::LAMP_GREEN;
	endproperty
	a_unsel_par: assert property (p_unsel_par) else $error("idle parallel lamp green");
	property p_green_vref; serial_lamp == pod_pkg::LAMP_GREEN |-> $past(vref_serial_in, 3); endproperty
	a_green_vref: assert property (p_green_vref) else $error("green without reference");
	property p_adapter_red;
		!adapter_port_oe_n && serial_lamp != pod_pkg::LAMP_AMBER
			|-> !serial_lamp.green && !parallel_config_port_lamp.green;
	endproperty
	a_adapter_red: assert property (p_adapter_red) else $error("green while adapter active");
	property p_blink;
		serial_lamp == pod_pkg::LAMP_OFF |-> parallel_config_port_lamp == pod_pkg::LAMP_OFF && !adapter_power;
	endproperty
	a_blink: assert property (p_blink) else $error("fault lamps out of step");
	property p_boot; $rose(hresetn) |-> !serial_port_oe_n; endproperty
	a_boot: assert property (p_boot) else $error("serial port not default");
endmodule : pod_chk

bind port_status_and_adapter_power pod_chk chk_u (
	.hclk                      (hclk),
	.hresetn                   (hresetn),
	.vref_serial_in            (vref_serial_in),
	.overcurrent_in            (overcurrent_in),
	.adapter_power             (adapter_power),
	.adapter_lamp              (adapter_lamp),
	.serial_lamp               (serial_lamp),
	.parallel_config_port_lamp (parallel_config_port_lamp),
	.serial_port_oe_n          (serial_port_oe_n),
	.parallel_config_port_oe_n (parallel_config_port_oe_n),
	.adapter_port_oe_n         (adapter_port_oe_n)
);

/* port_status_and_adapter_power_tb.sv */
`timescale 1ns/100ps
module port_status_and_adapter_power_tb;
	logic           hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
	logic [31:0]    haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0]     htrans = 0;
	logic           hreadyout, hresp, adapter_power, adapter_lamp, irq, ovc, vs_pin, vp_pin;
	logic           oe_s, oe_p, oe_a, shorted = 0, vs = 0, vp = 0;
	logic [3:0]     id = 4'h5, id_pin;
	pod_pkg::lamp_s sl, pl;
	int             fail_count = 0, checked = 0;

	// ----------------------------------------------------------------
	// Clock, bus ready and instances
	// ----------------------------------------------------------------
	always #20 hclk = ~hclk;
	assign hready = hreadyout;

	port_status_and_adapter_power #(.BLINK_HALF_CYCLES(8), .ID_W(4)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .vref_serial_in(vs_pin), .vref_parallel_in(vp_pin), .overcurrent_in(ovc),
		.adapter_id_in(id_pin), .adapter_power(adapter_power), .adapter_lamp(adapter_lamp),
		.serial_lamp(sl), .parallel_config_port_lamp(pl), .serial_port_oe_n(oe_s),
		.parallel_config_port_oe_n(oe_p), .adapter_port_oe_n(oe_a), .irq(irq));
	target_model tgt_u (.adapter_power(adapter_power), .shorted(shorted), .vref_ser_on(vs),
		.vref_par_on(vp), .id(id), .vref_serial_in(vs_pin), .vref_parallel_in(vp_pin),
		.overcurrent_in(ovc), .adapter_id_in(id_pin));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task stop_test;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task wait_rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				fail_count++;
				stop_test();
			end
			@(posedge hclk);
		end
	endtask : wait_rdy

	// One single AHB transfer, address phase then data phase
	task xfer(input logic [3:0] a, input logic wr, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {28'h0, a};
		hwrite <= wr;
		wait_rdy();
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : xfer

	task settle(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : settle

	task pins(input logic [2:0] oe, input logic [1:0] s, input logic [1:0] p);
		chk("oe", {29'h0, oe}, {29'h0, oe_s, oe_p, oe_a});
		chk("serial_lamp", {30'h0, s}, {30'h0, sl});
		chk("parallel_lamp", {30'h0, p}, {30'h0, pl});
	endtask : pins

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_boot;
		settle(1);
		pins(3'b011, pod_pkg::LAMP_AMBER, pod_pkg::LAMP_AMBER);
		chk("power", 32'h0, {31'h0, adapter_power});
		xfer(pod_pkg::OFS_CTRL, 0, 0);
		chk("ctrl", 32'h0, q);
	endtask : t_boot

	task t_lamps;
		xfer(pod_pkg::OFS_CTRL, 1, 32'h10);
		vs <= 1;
		settle(4);
		pins(3'b011, pod_pkg::LAMP_GREEN, pod_pkg::LAMP_RED);
		@(posedge hclk) vs <= 0;
		settle(4);
		pins(3'b011, pod_pkg::LAMP_AMBER, pod_pkg::LAMP_RED);
		xfer(pod_pkg::OFS_CTRL, 1, 32'h11);
		vp <= 1;
		settle(4);
		pins(3'b101, pod_pkg::LAMP_RED, pod_pkg::LAMP_GREEN);
		xfer(pod_pkg::OFS_CTRL, 1, 32'h13);
		settle(2);
		pins(3'b101, pod_pkg::LAMP_RED, pod_pkg::LAMP_GREEN);
		xfer(pod_pkg::OFS_CTRL, 1, 32'h12);
		settle(2);
		pins(3'b110, pod_pkg::LAMP_RED, pod_pkg::LAMP_RED);
	endtask : t_lamps

	task t_power;
		xfer(pod_pkg::OFS_IRQ_MASK, 1, 32'hf);
		xfer(pod_pkg::OFS_IRQ_STATUS, 1, 32'hf);
		xfer(pod_pkg::OFS_CTRL, 1, 32'h16);
		settle(2);
		chk("power_on", 32'h3, {30'h0, adapter_power, adapter_lamp});
		chk("irq_idle", 32'h0, {31'h0, irq});
		xfer(pod_pkg::OFS_STATUS, 0, 0);
		chk("status", 32'h256, q);
		xfer(pod_pkg::OFS_CTRL, 1, 32'h1a);
		settle(2);
		chk("power_off", 32'h0, {30'h0, adapter_power, adapter_lamp});
		chk("irq_done", 32'h1, {31'h0, irq});
		xfer(pod_pkg::OFS_IRQ_STATUS, 0, 0);
		chk("irq_status", 32'h8, q);
		xfer(pod_pkg::OFS_IRQ_STATUS, 1, 32'h8);
		xfer(pod_pkg::OFS_IRQ_MASK, 1, 32'h0);
		id <= 4'ha;
		settle(5);
		chk("irq_masked", 32'h0, {31'h0, irq});
		xfer(pod_pkg::OFS_IRQ_STATUS, 0, 0);
		chk("irq_id", 32'h2, q);
		vs <= 1;
		settle(4);
		xfer(pod_pkg::OFS_IRQ_STATUS, 0, 0);
		chk("irq_vref", 32'h6, q);
		xfer(pod_pkg::OFS_IRQ_STATUS, 1, 32'h6);
		xfer(pod_pkg::OFS_IRQ_MASK, 1, 32'hf);
		xfer(pod_pkg::OFS_CTRL, 0, 0);
		chk("ctrl_back", 32'h12, q);
	endtask : t_power

	// Power the adapter, short it, watch the cut and the blinking
	task short_out;
		int nr, no;
		nr = 0;
		no = 0;
		xfer(pod_pkg::OFS_CTRL, 1, 32'h16);
		shorted <= 1;
		settle(5);
		chk("ovc_cut", 32'h0, {31'h0, adapter_power});
		repeat (40) begin
			settle(1);
			chk("blink_pair", {30'h0, sl}, {30'h0, pl});
			chk("held_off", 32'h0, {31'h0, adapter_power});
			nr += (sl === pod_pkg::LAMP_RED);
			no += (sl === pod_pkg::LAMP_OFF);
		end
		chk("blinked", 32'h1, {31'h0, nr > 0 && no > 0});
		@(posedge hclk) shorted <= 0;
	endtask : short_out

	task t_fault;
		short_out();
		xfer(pod_pkg::OFS_IRQ_STATUS, 0, 0);
		chk("irq_fault", 32'h1, q);
		xfer(pod_pkg::OFS_STATUS, 0, 0);
		chk("fault_bit", 32'h1, {31'h0, q[3]});
		xfer(pod_pkg::OFS_CTRL, 1, 32'h16);
		settle(2);
		chk("restart", 32'h1, {31'h0, adapter_power});
		xfer(pod_pkg::OFS_CTRL, 1, 32'h1a);
		short_out();
		xfer(pod_pkg::OFS_CTRL, 1, 32'h32);
		settle(20);
		pins(3'b110, pod_pkg::LAMP_RED, pod_pkg::LAMP_RED);
		xfer(pod_pkg::OFS_STATUS, 0, 0);
		chk("cleared", 32'h0, {30'h0, q[3:2]});
		xfer(pod_pkg::OFS_CTRL, 1, 32'h10);
		xfer(pod_pkg::OFS_CTRL, 1, 32'h16);
		settle(2);
		chk("sel_start", 32'h1, {31'h0, adapter_power});
		xfer(pod_pkg::OFS_CTRL, 1, 32'h10);
		settle(2);
		chk("desel_off", 32'h0, {31'h0, adapter_power});
	endtask : t_fault

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1;
		t_boot();
		t_lamps();
		t_power();
		t_fault();
		stop_test();
	end
endmodule : port_status_and_adapter_power_tb
